/* acc_pkg.sv */
package acc_pkg;
	// ****************************************************
	// widths
	// ****************************************************
	localparam int CODE_W = 10;
	localparam int ACC_W  = 16;
	localparam int CNT_W  = 7;

	// ****************************************************
	// format select encodings
	// ****************************************************
	localparam logic [2:0] FMT_RIGHT  = 3'h0;
	localparam logic [2:0] FMT_SHR1   = 3'h1;
	localparam logic [2:0] FMT_SHR2   = 3'h2;
	localparam logic [2:0] FMT_SHR3   = 3'h3;
	localparam logic [2:0] FMT_LEFT   = 3'h4;
	localparam int         LEFT_SHIFT = ACC_W - CODE_W;

	// ****************************************************
	// repeat count encodings
	// ****************************************************
	localparam logic [2:0] RPT_1  = 3'h0;
	localparam logic [2:0] RPT_4  = 3'h1;
	localparam logic [2:0] RPT_8  = 3'h2;
	localparam logic [2:0] RPT_16 = 3'h3;
	localparam logic [2:0] RPT_32 = 3'h4;
	localparam logic [2:0] RPT_64 = 3'h5;

	localparam logic [ACC_W-1:0] ACC_RESET = 16'h0000;

	function automatic logic [CNT_W-1:0] rpt_len(input logic [2:0] sel);
		unique case (sel)
			RPT_4:   rpt_len = 7'h04;
			RPT_8:   rpt_len = 7'h08;
			RPT_16:  rpt_len = 7'h10;
			RPT_32:  rpt_len = 7'h20;
			RPT_64:  rpt_len = 7'h40;
			default: rpt_len = 7'h01;
		endcase
	endfunction : rpt_len
endpackage : acc_pkg

/* sample_if.sv */
`timescale 1ns/1ps
interface sample_if;
	logic                         valid;
	logic [acc_pkg::CODE_W-1:0]   code;
	logic                         first;
	logic                         last;
	modport src (output valid, output code, output first, output last);
	modport snk (input valid, input code, input first, input last);
endinterface : sample_if

/* sample_accumulator.sv */
`timescale 1ns/1ps
module sample_accumulator (
	input  wire logic                       clk_in,
	input  wire logic                       rst_in,
	sample_if.snk                           smp,
	output logic [acc_pkg::ACC_W-1:0]       sum_out,
	output logic                            sum_valid_out
);
	logic [acc_pkg::ACC_W-1:0] acc_reg;
	logic [acc_pkg::ACC_W-1:0] acc_next;

	// series restarts from zero on its first sample
	always_comb begin
		acc_next = (smp.first ? acc_pkg::ACC_RESET : acc_reg)
			+ acc_pkg::ACC_W'(smp.code);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_reg <= acc_pkg::ACC_RESET;
		end else if (smp.valid) begin
			acc_reg <= acc_next;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sum_out       <= acc_pkg::ACC_RESET;
			sum_valid_out <= 1'b0;
		end else begin
			sum_valid_out <= smp.valid && smp.last;
			if (smp.valid && smp.last) begin
				sum_out <= acc_next;
			end
		end
	end
endmodule : sample_accumulator

/* adc_result_accumulator_format.sv */
`timescale 1ns/1ps
module adc_result_accumulator_format (
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	input  wire logic [2:0]                  result_format_select_in,
	input  wire logic [2:0]                  repeat_count_select_in,
	input  wire logic                        burst_mode_enable_in,
	input  wire logic                        convert_start_in,
	input  wire logic                        core_ready_in,
	input  wire logic                        core_done_in,
	input  wire logic [acc_pkg::CODE_W-1:0]  core_code_in,
	input  wire logic                        done_clear_in,
	output logic                             core_power_out,
	output logic                             core_start_out,
	output logic [7:0]                       result_high_byte_out,
	output logic [7:0]                       result_low_byte_out,
	output logic                             conversion_done_flag_out
);
	typedef enum logic [1:0] {S_IDLE, S_POWER, S_CONVERT, S_WAIT} burst_state_e;

	burst_state_e                    state_reg;
	logic [acc_pkg::CNT_W-1:0]       count_reg;
	logic [acc_pkg::CNT_W-1:0]       burst_left_reg;
	logic [acc_pkg::ACC_W-1:0]       sum;
	logic                            sum_valid;
	logic                            is_first;
	logic                            is_last;
	logic [acc_pkg::CNT_W-1:0]       series_len;

	sample_if smp ();

	// ****************************************************
	// series tracking
	// ****************************************************
	assign series_len = acc_pkg::rpt_len(repeat_count_select_in);
	assign is_first   = (count_reg == '0);
	assign is_last    = (count_reg + 7'h01 >= series_len);

	assign smp.valid = core_done_in;
	assign smp.code  = core_code_in;
	assign smp.first = is_first;
	assign smp.last  = is_last;

	// counter holds samples already summed in this series
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_reg <= '0;
		end else if (core_done_in) begin
			count_reg <= is_last ? '0 : count_reg + 7'h01;
		end
	end

	sample_accumulator u_acc (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.smp           (smp),
		.sum_out       (sum),
		.sum_valid_out (sum_valid)
	);

	// ****************************************************
	// formatting
	// ****************************************************
	function automatic logic [acc_pkg::ACC_W-1:0] fmt(input logic [2:0] sel,
		input logic [acc_pkg::ACC_W-1:0] v);
		unique case (sel)
			acc_pkg::FMT_SHR1: fmt = v >> 1;
			acc_pkg::FMT_SHR2: fmt = v >> 2;
			acc_pkg::FMT_SHR3: fmt = v >> 3;
			acc_pkg::FMT_LEFT: fmt = v << acc_pkg::LEFT_SHIFT;
			default:           fmt = v;
		endcase
	endfunction : fmt

	// shift fills with zeros, so unused bits read zero
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			result_high_byte_out <= 8'h00;
			result_low_byte_out  <= 8'h00;
		end else if (sum_valid) begin
			{result_high_byte_out, result_low_byte_out}
				<= fmt(result_format_select_in, sum);
		end
	end

	// set wins over software clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			conversion_done_flag_out <= 1'b0;
		end else if (sum_valid) begin
			conversion_done_flag_out <= 1'b1;
		end else if (done_clear_in) begin
			conversion_done_flag_out <= 1'b0;
		end
	end

	// ****************************************************
	// conversion sequencing
	// ****************************************************
	// non-burst: each start is one conversion, core kept powered
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg      <= S_IDLE;
			burst_left_reg <= '0;
			core_power_out <= 1'b0;
			core_start_out <= 1'b0;
		end else begin
			core_start_out <= 1'b0;
			unique case (state_reg)
				S_IDLE: begin
					core_power_out <= !burst_mode_enable_in;
					if (convert_start_in) begin
						burst_left_reg <= burst_mode_enable_in ? series_len : 7'h01;
						core_power_out <= 1'b1;
						state_reg      <= S_POWER;
					end
				end
				S_POWER: begin
					if (core_ready_in) begin
						core_start_out <= 1'b1;
						state_reg      <= S_CONVERT;
					end
				end
				S_CONVERT: begin
					state_reg <= S_WAIT;
				end
				S_WAIT: begin
					if (core_done_in) begin
						if (burst_left_reg == 7'h01) begin
							core_power_out <= !burst_mode_enable_in;
							state_reg      <= S_IDLE;
						end else begin
							burst_left_reg <= burst_left_reg - 7'h01;
							core_start_out <= 1'b1;
							state_reg      <= S_CONVERT;
						end
					end
				end
			endcase
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	property p_done_after_sum;
		@(posedge clk_in) disable iff (rst_in)
		sum_valid |=> conversion_done_flag_out;
	endproperty
	a_done_after_sum: assert property (p_done_after_sum) else $error("done flag not set");

	property p_no_early_done;
		@(posedge clk_in) disable iff (rst_in)
		$rose(conversion_done_flag_out) |-> $past(sum_valid);
	endproperty
	a_no_early_done: assert property (p_no_early_done) else $error("done flag early");

	property p_result_stable;
		@(posedge clk_in) disable iff (rst_in)
		!$past(sum_valid) |-> $stable({result_high_byte_out, result_low_byte_out});
	endproperty
	a_result_stable: assert property (p_result_stable) else $error("result changed");

	property p_right_fmt;
		@(posedge clk_in) disable iff (rst_in)
		sum_valid && result_format_select_in == acc_pkg::FMT_RIGHT
		|=> {result_high_byte_out, result_low_byte_out} == $past(sum);
	endproperty
	a_right_fmt: assert property (p_right_fmt) else $error("right justify wrong");

	property p_left_zero;
		@(posedge clk_in) disable iff (rst_in)
		$past(sum_valid) && $past(result_format_select_in) == acc_pkg::FMT_LEFT
		|-> result_low_byte_out[5:0] == 6'h00;
	endproperty
	a_left_zero: assert property (p_left_zero) else $error("unused bits set");

	property p_single_range;
		@(posedge clk_in) disable iff (rst_in)
		sum_valid && series_len == 7'h01 |-> sum[15:10] == 6'h00;
	endproperty
	a_single_range: assert property (p_single_range) else $error("single code too wide");

	property p_burst_off;
		@(posedge clk_in) disable iff (rst_in)
		state_reg == S_WAIT && core_done_in && burst_left_reg == 7'h01
			&& burst_mode_enable_in |=> !core_power_out;
	endproperty
	a_burst_off: assert property (p_burst_off) else $error("core not shut down");

	property p_burst_power;
		@(posedge clk_in) disable iff (rst_in)
		state_reg == S_IDLE && convert_start_in |=> core_power_out;
	endproperty
	a_burst_power: assert property (p_burst_power) else $error("core not powered");

	property p_shr1;
		@(posedge clk_in) disable iff (rst_in)
		sum_valid && result_format_select_in == acc_pkg::FMT_SHR1
		|=> {result_high_byte_out, result_low_byte_out} == ($past(sum) >> 1);
	endproperty
	a_shr1: assert property (p_shr1) else $error("shift right wrong");
endmodule : adc_result_accumulator_format

/* core_model.sv */
`timescale 1ns/1ps
// ****************************************
// converter core stand-in
// ****************************************
module core_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       power_in,
	input  wire logic       start_in,
	input  wire logic [9:0] code_set_in,
	input  wire logic [3:0] lat_in,
	output logic            ready_out,
	output logic            done_out,
	output logic [9:0]      code_out
);
	logic [3:0] cnt_reg;
	logic       busy_reg;
	logic [9:0] last_reg;
	// stale code is inverted so a late sample never matches by luck
	assign code_out = done_out ? last_reg : ~last_reg;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_out <= 1'b0;
			done_out  <= 1'b0;
			busy_reg  <= 1'b0;
			cnt_reg   <= 4'h0;
			last_reg  <= 10'h000;
		end else begin
			ready_out <= power_in;
			done_out  <= 1'b0;
			if (start_in) begin
				busy_reg <= 1'b1;
				cnt_reg  <= lat_in;
			end else if (busy_reg) begin
				if (cnt_reg == 4'h0) begin
					busy_reg <= 1'b0;
					done_out <= 1'b1;
					last_reg <= code_set_in;
				end else begin
					cnt_reg <= cnt_reg - 4'h1;
				end
			end
		end
	end
endmodule : core_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
	logic       clk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic [2:0] fmt = 3'h0;
	logic [2:0] rpt = 3'h0;
	logic       bst = 1'b0;
	logic       st = 1'b0;
	logic       clr = 1'b0;
	logic [9:0] code_set = 10'h000;
	logic [3:0] lat = 4'h2;
	logic       pwr, cst, rdy, cdone, flag;
	logic [9:0] ccode;
	logic [7:0] hi, lo;
	int         miscompares = 0;
	int         num_checks = 0;
	always #5 clk_in = ~clk_in;
	core_model M (.clk_in(clk_in), .rst_in(rst_in), .power_in(pwr), .start_in(cst),
		.code_set_in(code_set), .lat_in(lat), .ready_out(rdy), .done_out(cdone),
		.code_out(ccode));
	adc_result_accumulator_format DUT (.clk_in(clk_in), .rst_in(rst_in),
		.result_format_select_in(fmt), .repeat_count_select_in(rpt),
		.burst_mode_enable_in(bst), .convert_start_in(st), .core_ready_in(rdy),
		.core_done_in(cdone), .core_code_in(ccode), .done_clear_in(clr),
		.core_power_out(pwr), .core_start_out(cst), .result_high_byte_out(hi),
		.result_low_byte_out(lo), .conversion_done_flag_out(flag));
	// ****************************************
	// checking
	// ****************************************
	task automatic finish_test;
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t result %h expected %h", $time, got, exp);
		end
	endtask : chk16
	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t flag bit %b expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic wait_done;
		int i;
		for (i = 0; i < 200 && cdone !== 1'b1; i++)
			@(negedge clk_in);
		if (i == 200) begin
			miscompares++;
			$display("BAD %0t no conversion finished", $time);
			finish_test();
		end else begin
			@(negedge clk_in);
		end
	endtask : wait_done
	// one series; leaves time for results to land
	task automatic series(input logic [2:0] f, input logic [2:0] r, input logic b,
			input logic [9:0] c, input int n);
		int k;
		@(negedge clk_in);
		fmt = f;
		rpt = r;
		bst = b;
		code_set = c;
		clr = 1'b1;
		@(negedge clk_in);
		clr = 1'b0;
		chk1(flag, 1'b0);
		for (k = 0; k < n; k++) begin
			if (k == 0 || !b) begin
				st = 1'b1;
				@(negedge clk_in);
				st = 1'b0;
			end
			wait_done();
			// manual starts only count from idle
			if (!b)
				repeat (3) @(negedge clk_in);
			if (k < n - 1)
				chk1(flag, 1'b0);
		end
		repeat (2) @(negedge clk_in);
	endtask : series
	// ****************************************
	// scenarios
	// ****************************************
	task automatic sc_single;
		series(acc_pkg::FMT_RIGHT, acc_pkg::RPT_1, 1'b0, 10'h3FF, 1);
		chk16({hi, lo}, 16'h03FF);
		chk1(flag, 1'b1);
		series(acc_pkg::FMT_LEFT, acc_pkg::RPT_1, 1'b0, 10'h3FF, 1);
		chk16({hi, lo}, 16'hFFC0);
		series(acc_pkg::FMT_LEFT, acc_pkg::RPT_1, 1'b0, 10'h200, 1);
		chk16({hi, lo}, 16'h8000);
		series(acc_pkg::FMT_RIGHT, acc_pkg::RPT_1, 1'b0, 10'h000, 1);
		chk16({hi, lo}, 16'h0000);
		chk1(pwr, 1'b1);
	endtask : sc_single
	task automatic sc_burst;
		int i;
		int n;
		logic [15:0] e;
		for (i = 1; i < 6; i++) begin
			n = 2 ** (i + 1);
			lat = (i % 2 == 1) ? 4'h0 : 4'h7;
			e = 16'(n * 32'h3FF) >> (i % 4);
			series(3'(i % 4), 3'(i), 1'b1, 10'h3FF, n);
			chk16({hi, lo}, e);
			chk1(flag, 1'b1);
			chk1(pwr, 1'b0);
		end
	endtask : sc_burst
	task automatic sc_manual;
		lat = 4'h9;
		series(acc_pkg::FMT_RIGHT, acc_pkg::RPT_4, 1'b0, 10'h155, 4);
		chk16({hi, lo}, 16'h0554);
		lat = 4'h1;
		series(acc_pkg::FMT_RIGHT, acc_pkg::RPT_8, 1'b0, 10'h001, 8);
		chk16({hi, lo}, 16'h0008);
		series(acc_pkg::FMT_RIGHT, acc_pkg::RPT_64, 1'b1, 10'h2AB, 64);
		chk16({hi, lo}, 16'hAAC0);
	endtask : sc_manual
	// clear lands in the same cycle as the set: set must win
	task automatic sc_clear_race;
		@(negedge clk_in);
		fmt = acc_pkg::FMT_RIGHT;
		rpt = acc_pkg::RPT_1;
		bst = 1'b0;
		code_set = 10'h0AA;
		st = 1'b1;
		@(negedge clk_in);
		st = 1'b0;
		wait_done();
		clr = 1'b1;
		@(negedge clk_in);
		clr = 1'b0;
		chk1(flag, 1'b1);
		chk16({hi, lo}, 16'h00AA);
	endtask : sc_clear_race
	initial begin
		repeat (16) @(negedge clk_in);
		rst_in = 1'b0;
		chk16({hi, lo}, 16'h0000);
		sc_single();
		sc_burst();
		sc_manual();
		sc_clear_race();
		finish_test();
	end
endmodule : tb
